//--- include/crs_regs.vh
// register offsets, flag bit positions and reset values of the cpu core register set
`ifndef CRS_REGS_VH
`define CRS_REGS_VH
`define CRS_OFF_DATA0 4'h0
`define CRS_OFF_DATA1 4'h1
`define CRS_OFF_DATA2 4'h2
`define CRS_OFF_DATA3 4'h3
`define CRS_OFF_ADDR0 4'h4
`define CRS_OFF_ADDR1 4'h5
`define CRS_OFF_FRAME 4'h6
`define CRS_OFF_VTAB 4'h7
`define CRS_OFF_PC 4'h8
`define CRS_OFF_USP 4'h9
`define CRS_OFF_ISP 4'hA
`define CRS_OFF_SBASE 4'hB
`define CRS_OFF_FLAG 4'hC
`define CRS_OFF_ASP 4'hD
`define CRS_FLG_C 0
`define CRS_FLG_D 1
`define CRS_FLG_Z 2
`define CRS_FLG_S 3
`define CRS_FLG_B 4
`define CRS_FLG_O 5
`define CRS_FLG_U 7
`define CRS_FLG_MASK 11'h0BF
`define CRS_RST_16 16'h0000
`define CRS_RST_20 20'h0_0000
`define CRS_RST_FLG 11'h000
`define CRS_UNMAPPED 32'hDEAD_0000
`define CRS_SEL_NONE 4'h0
`define CRS_SEL_BYTE_LO 4'h1
`define CRS_SEL_BYTE_HI 4'h2
`define CRS_SEL_WORD 4'h3
`define CRS_SEL_PAIR 4'h4
`endif

//--- verilog/crs_bank.v
// one register bank: four data registers, two address registers and frame base
`timescale 1ns/100ps
`include "crs_regs.vh"
module crs_bank
(
    input wire sys_clk,
    input wire resetn,
    input wire [3:0] wrIdx,
    input wire [3:0] wrSel,
    input wire [31:0] wrData,
    input wire [3:0] rdIdx,
    output reg [31:0] rdData
);
    reg [15:0] regFile [0:6];
    genvar i;
    generate
        for (i = 0; i < 7; i = i + 1)
        begin : g_reg
            wire hit;
            wire pairHit;
            // pair partner: index 2 backs data0, 3 backs data1, addr1 backs addr0
            assign hit = (wrIdx == i);
            assign pairHit = (wrSel == `CRS_SEL_PAIR) &&
                ((i == 2 && wrIdx == 4'd0) || (i == 3 && wrIdx == 4'd1) ||
                (i == 5 && wrIdx == 4'd4));
            always @(posedge sys_clk or negedge resetn)
            begin
                if (!resetn)
                    regFile[i] <= `CRS_RST_16;
                else if (pairHit)
                    regFile[i] <= wrData[31:16];
                else if (hit && (wrSel == `CRS_SEL_WORD || wrSel == `CRS_SEL_PAIR))
                    regFile[i] <= wrData[15:0];
                else if (hit && wrSel == `CRS_SEL_BYTE_LO && i < 2)
                    regFile[i][7:0] <= wrData[7:0];
                else if (hit && wrSel == `CRS_SEL_BYTE_HI && i < 2)
                    regFile[i][15:8] <= wrData[7:0];
            end
        end
    endgenerate
    always @*
    begin
        case (rdIdx)
            4'd0: rdData = {regFile[2], regFile[0]};
            4'd1: rdData = {regFile[3], regFile[1]};
            4'd2: rdData = {16'h0000, regFile[2]};
            4'd3: rdData = {16'h0000, regFile[3]};
            4'd4: rdData = {regFile[5], regFile[4]};
            4'd5: rdData = {16'h0000, regFile[5]};
            4'd6: rdData = {16'h0000, regFile[6]};
            default: rdData = 32'h0000_0000;
        endcase
    end
endmodule // crs_bank

//--- verilog/crs_flags.v
// flag register with alu-driven condition flags
`timescale 1ns/100ps
`include "crs_regs.vh"
module crs_flags
(
    input wire sys_clk,
    input wire resetn,
    input wire swWrite,
    input wire [10:0] swData,
    input wire aluValid,
    input wire [15:0] aluResult,
    input wire aluCarry,
    input wire aluOverflow,
    output reg [10:0] flags
);
    reg [10:0] flagsNext;
    always @*
    begin
        flagsNext = flags;
        if (swWrite)
            flagsNext = swData & `CRS_FLG_MASK;
        if (aluValid)
        begin
            // alu update of C, Z, S and O wins over a software write in the same cycle
            flagsNext[`CRS_FLG_C] = aluCarry;
            flagsNext[`CRS_FLG_Z] = (aluResult == 16'h0000);
            flagsNext[`CRS_FLG_S] = aluResult[15];
            flagsNext[`CRS_FLG_O] = aluOverflow;
        end
    end
    always @(posedge sys_clk or negedge resetn)
    begin
        if (!resetn)
            flags <= `CRS_RST_FLG;
        else
            flags <= flagsNext;
    end
endmodule // crs_flags

//--- verilog/crs_core_regs.v
// cpu core register set with avalon-mm slave and alu flag port
`timescale 1ns/100ps
`include "crs_regs.vh"
module crs_core_regs
(
    input wire sys_clk,
    input wire resetn,
    input wire [3:0] avs_address,
    input wire avs_read,
    input wire avs_write,
    input wire [31:0] avs_writedata,
    input wire [3:0] avs_byteenable,
    output reg [31:0] avs_readdata,
    output reg avs_waitrequest,
    input wire aluValid,
    input wire [15:0] aluResult,
    input wire aluCarry,
    input wire aluOverflow,
    input wire pcLoad,
    input wire [19:0] pcLoadValue,
    input wire pcStep,
    input wire [2:0] pcStepSize,
    output reg [19:0] programCounter,
    output reg [15:0] activeStackPointer,
    output reg bankSelect
);
    localparam BUS_IDLE = 1'b0;
    localparam BUS_ACK = 1'b1;

    reg [15:0] userStackPointer_reg;
    reg [15:0] interruptStackPointer_reg;
    reg [15:0] staticBase_reg;
    reg [19:0] vectorTableBase_reg;
    reg [19:0] programCounter_reg;
    reg [19:0] programCounter_next;
    reg busState_reg;
    reg busState_next;
    reg waitrequest_next;
    reg [31:0] readdata_next;
    reg [15:0] activeStack_next;
    reg [3:0] bankSel;
    reg [3:0] bankIdx;
    reg [31:0] bankWrData;
    reg [31:0] readMux;
    wire [10:0] flags;
    wire [31:0] bank0Data;
    wire [31:0] bank1Data;
    wire [31:0] bankRead;
    wire [3:0] bank0Sel;
    wire [3:0] bank1Sel;
    wire [19:0] pcStepWide;
    wire bankFlag;
    wire stackFlag;
    wire req;
    wire newReq;
    wire accepted;
    wire wr;
    wire flagWrite;
    wire bankWrite;
    wire hitBank;
    wire hitUser;
    wire hitIntr;
    wire hitActive;
    wire hitStatic;
    wire hitVector;
    wire hitCounter;
    wire hitFlag;
    wire laneLow;
    wire laneHigh;
    wire laneWord;
    wire laneAll;
    wire pairAddr;
    wire wrUser;
    wire wrIntr;
    wire wrStatic;
    wire wrVector;
    wire wrCounter;
    wire [31:0] vectorWord;
    wire [31:0] counterWord;
    wire [31:0] userWord;
    wire [31:0] intrWord;
    wire [31:0] staticWord;
    wire [31:0] flagWord;
    wire [31:0] activeWord;

    // one wait state per access keeps the read mux off the bus path
    assign req = avs_read || avs_write;
    assign newReq = req && (busState_reg == BUS_IDLE);
    assign accepted = req && (busState_reg == BUS_ACK);
    assign wr = avs_write && accepted;
    assign bankFlag = flags[`CRS_FLG_B];
    assign stackFlag = flags[`CRS_FLG_U];

    // one address decode shared by the write strobes
    assign hitBank = (avs_address <= `CRS_OFF_FRAME);
    assign hitUser = (avs_address == `CRS_OFF_USP);
    assign hitIntr = (avs_address == `CRS_OFF_ISP);
    assign hitActive = (avs_address == `CRS_OFF_ASP);
    assign hitStatic = (avs_address == `CRS_OFF_SBASE);
    assign hitVector = (avs_address == `CRS_OFF_VTAB);
    assign hitCounter = (avs_address == `CRS_OFF_PC);
    assign hitFlag = (avs_address == `CRS_OFF_FLAG);

    // the alias writes whichever stack pointer the flag selects at that edge
    assign flagWrite = wr && hitFlag;
    assign bankWrite = wr && hitBank;
    assign wrUser = wr && (hitUser || (hitActive && stackFlag));
    assign wrIntr = wr && (hitIntr || (hitActive && !stackFlag));
    assign wrStatic = wr && hitStatic;
    assign wrVector = wr && hitVector;
    assign wrCounter = wr && hitCounter;

    // byte lanes pick the access width for the halves
    assign laneLow = (avs_byteenable == 4'b0001);
    assign laneHigh = (avs_byteenable == 4'b0010);
    assign laneAll = (avs_byteenable == 4'b1111);
    assign laneWord = (avs_byteenable[1:0] == 2'b11);
    assign pairAddr = (avs_address == `CRS_OFF_DATA0) || (avs_address == `CRS_OFF_DATA1) ||
        (avs_address == `CRS_OFF_ADDR0);

    always @*
    begin
        bankIdx = avs_address;
        bankSel = `CRS_SEL_NONE;
        if (bankWrite)
        begin
            if (laneLow)
                bankSel = `CRS_SEL_BYTE_LO;
            else if (laneHigh)
                bankSel = `CRS_SEL_BYTE_HI;
            else if (laneAll && pairAddr)
                bankSel = `CRS_SEL_PAIR;
            else if (laneWord)
                bankSel = `CRS_SEL_WORD;
        end
    end

    // the high byte moves down so both halves share one write path into the bank
    always @*
    begin
        if (laneHigh)
            bankWrData = {24'h00_0000, avs_writedata[15:8]};
        else
            bankWrData = avs_writedata;
    end

    // only the selected bank sees write strobes; the other keeps its contents
    assign bank0Sel = bankFlag ? `CRS_SEL_NONE : bankSel;
    assign bank1Sel = bankFlag ? bankSel : `CRS_SEL_NONE;
    assign bankRead = bankFlag ? bank1Data : bank0Data;

    crs_bank u_bank0
    (
        .sys_clk(sys_clk),
        .resetn(resetn),
        .wrIdx(bankIdx),
        .wrSel(bank0Sel),
        .wrData(bankWrData),
        .rdIdx(avs_address),
        .rdData(bank0Data)
    );

    crs_bank u_bank1
    (
        .sys_clk(sys_clk),
        .resetn(resetn),
        .wrIdx(bankIdx),
        .wrSel(bank1Sel),
        .wrData(bankWrData),
        .rdIdx(avs_address),
        .rdData(bank1Data)
    );

    crs_flags u_flags
    (
        .sys_clk(sys_clk),
        .resetn(resetn),
        .swWrite(flagWrite),
        .swData(avs_writedata[10:0]),
        .aluValid(aluValid),
        .aluResult(aluResult),
        .aluCarry(aluCarry),
        .aluOverflow(aluOverflow),
        .flags(flags)
    );

    // stack pointers, static base and vector table base change only on an accepted write
    always @(posedge sys_clk or negedge resetn)
    begin
        if (!resetn)
            userStackPointer_reg <= `CRS_RST_16;
        else if (wrUser)
            userStackPointer_reg <= avs_writedata[15:0];
    end

    always @(posedge sys_clk or negedge resetn)
    begin
        if (!resetn)
            interruptStackPointer_reg <= `CRS_RST_16;
        else if (wrIntr)
            interruptStackPointer_reg <= avs_writedata[15:0];
    end

    always @(posedge sys_clk or negedge resetn)
    begin
        if (!resetn)
            staticBase_reg <= `CRS_RST_16;
        else if (wrStatic)
            staticBase_reg <= avs_writedata[15:0];
    end

    always @(posedge sys_clk or negedge resetn)
    begin
        if (!resetn)
            vectorTableBase_reg <= `CRS_RST_20;
        else if (wrVector)
            vectorTableBase_reg <= avs_writedata[19:0];
    end

    assign pcStepWide = {17'h0_0000, pcStepSize};

    always @*
    begin
        programCounter_next = programCounter_reg;
        // a bus write beats the datapath, and a load beats a step
        if (wrCounter)
            programCounter_next = avs_writedata[19:0];
        else if (pcLoad)
            programCounter_next = pcLoadValue;
        else if (pcStep)
            programCounter_next = programCounter_reg + pcStepWide;
    end

    always @(posedge sys_clk or negedge resetn)
    begin
        if (!resetn)
            programCounter_reg <= `CRS_RST_20;
        else
            programCounter_reg <= programCounter_next;
    end

    // zero-extended read words for the registers outside the banks
    assign vectorWord = {12'h000, vectorTableBase_reg};
    assign counterWord = {12'h000, programCounter_reg};
    assign userWord = {16'h0000, userStackPointer_reg};
    assign intrWord = {16'h0000, interruptStackPointer_reg};
    assign staticWord = {16'h0000, staticBase_reg};
    assign flagWord = {21'h00_0000, flags};
    assign activeWord = {16'h0000, activeStack_next};

    always @*
    begin
        if (stackFlag)
            activeStack_next = userStackPointer_reg;
        else
            activeStack_next = interruptStackPointer_reg;
    end

    always @*
    begin
        case (avs_address)
            `CRS_OFF_DATA0, `CRS_OFF_DATA1, `CRS_OFF_DATA2, `CRS_OFF_DATA3,
            `CRS_OFF_ADDR0, `CRS_OFF_ADDR1, `CRS_OFF_FRAME:
                readMux = bankRead;
            `CRS_OFF_VTAB: readMux = vectorWord;
            `CRS_OFF_PC: readMux = counterWord;
            `CRS_OFF_USP: readMux = userWord;
            `CRS_OFF_ISP: readMux = intrWord;
            `CRS_OFF_SBASE: readMux = staticWord;
            `CRS_OFF_FLAG: readMux = flagWord;
            `CRS_OFF_ASP: readMux = activeWord;
            default: readMux = `CRS_UNMAPPED;
        endcase
    end

    // first edge of a request loads read data and drops waitrequest for the next edge
    always @*
    begin
        busState_next = busState_reg;
        waitrequest_next = 1'b1;
        readdata_next = avs_readdata;
        case (busState_reg)
            BUS_IDLE:
            begin
                if (newReq)
                begin
                    busState_next = BUS_ACK;
                    waitrequest_next = 1'b0;
                    readdata_next = readMux;
                end
            end
            BUS_ACK:
            begin
                busState_next = BUS_IDLE;
            end
            default:
            begin
                busState_next = BUS_IDLE;
            end
        endcase
    end

    always @(posedge sys_clk or negedge resetn)
    begin
        if (!resetn)
            busState_reg <= BUS_IDLE;
        else
            busState_reg <= busState_next;
    end

    always @(posedge sys_clk or negedge resetn)
    begin
        if (!resetn)
            avs_waitrequest <= 1'b1;
        else
            avs_waitrequest <= waitrequest_next;
    end

    always @(posedge sys_clk or negedge resetn)
    begin
        if (!resetn)
            avs_readdata <= 32'h0000_0000;
        else
            avs_readdata <= readdata_next;
    end

    always @(posedge sys_clk or negedge resetn)
    begin
        if (!resetn)
        begin
            programCounter <= `CRS_RST_20;
            activeStackPointer <= `CRS_RST_16;
            bankSelect <= 1'b0;
        end
        else
        begin
            programCounter <= programCounter_next;
            activeStackPointer <= activeStack_next;
            bankSelect <= bankFlag;
        end
    end
endmodule // crs_core_regs

//--- test/crs_core_regs_checker.sv
// port assertions for the core register set
`timescale 1ns/100ps
module crs_core_regs_checker
(
    input wire sys_clk,
    input wire resetn,
    input wire [3:0] avs_address,
    input wire avs_read,
    input wire avs_write,
    input wire [31:0] avs_writedata,
    input wire [31:0] avs_readdata,
    input wire avs_waitrequest,
    input wire aluValid,
    input wire pcLoad,
    input wire [19:0] pcLoadValue,
    input wire pcStep,
    input wire [2:0] pcStepSize,
    input wire [19:0] programCounter,
    input wire bankSelect
);
    default clocking cb @(posedge sys_clk);
    endclocking
    default disable iff (!resetn);
    wire req = avs_read || avs_write;
    // a bus write to the counter wins over load and step
    wire pcBusWr = avs_write && !avs_waitrequest && avs_address == 4'h8;
    sequence s_flag_wr;
        avs_write && !avs_waitrequest && avs_address == 4'hC && !aluValid;
    endsequence
    sequence s_unmapped_rd;
        avs_read && !avs_waitrequest && avs_address[3:1] == 3'b111;
    endsequence
    a_wait_one: assert property (req && avs_waitrequest |=> !avs_waitrequest)
        else $error("no answer one cycle after request");
    a_wait_pulse: assert property (!avs_waitrequest |=> avs_waitrequest)
        else $error("answer held longer than one cycle");
    a_wait_idle: assert property (!req |=> avs_waitrequest)
        else $error("answer without request");
    a_unmapped_read: assert property (s_unmapped_rd |-> avs_readdata == 32'hDEAD_0000)
        else $error("unmapped read pattern wrong");
    a_bank_track: assert property (
        s_flag_wr |=> ##1 bankSelect == $past(avs_writedata[4], 2))
        else $error("bank select not following flag write");
    a_pc_load: assert property (
        pcLoad && !pcBusWr |=> programCounter == $past(pcLoadValue))
        else $error("counter load lost");
    a_pc_step: assert property (
        pcStep && !pcLoad && !pcBusWr |=> programCounter == $past(programCounter) + $past(pcStepSize))
        else $error("counter step wrong");
    a_pc_hold: assert property (
        !pcLoad && !pcStep && !pcBusWr |=> $stable(programCounter))
        else $error("counter moved without cause");
endmodule // crs_core_regs_checker

bind crs_core_regs crs_core_regs_checker u_chk
(
    .sys_clk(sys_clk), .resetn(resetn), .avs_address(avs_address), .avs_read(avs_read),
    .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .aluValid(aluValid), .pcLoad(pcLoad),
    .pcLoadValue(pcLoadValue), .pcStep(pcStep), .pcStepSize(pcStepSize),
    .programCounter(programCounter), .bankSelect(bankSelect)
);

//--- test/crs_dp_model.sv
// execution datapath stand-in driving the alu and program counter ports
`timescale 1ns/100ps
module crs_dp_model
(
    input wire sys_clk,
    output reg aluValid,
    output reg [15:0] aluResult,
    output reg aluCarry,
    output reg aluOverflow,
    output reg pcLoad,
    output reg [19:0] pcLoadValue,
    output reg pcStep,
    output reg [2:0] pcStepSize
);
    initial
    begin
        {aluValid, aluResult, aluCarry, aluOverflow, pcLoad, pcLoadValue, pcStep, pcStepSize} = 44'h000_0000_0000;
    end
    // operands are inverted after the strobe so stale values are never mistaken for fresh ones
    task alu(input [15:0] r, input c, input o);
    begin
        @(posedge sys_clk);
        aluValid <= 1'b1;
        {aluResult, aluCarry, aluOverflow} <= {r, c, o};
        @(posedge sys_clk);
        aluValid <= 1'b0;
        {aluResult, aluCarry, aluOverflow} <= ~{r, c, o};
    end
    endtask
    task pc(input ld, input [19:0] v, input [2:0] n);
    begin
        @(posedge sys_clk);
        {pcLoad, pcLoadValue} <= {ld, v};
        {pcStep, pcStepSize} <= {!ld, n};
        @(posedge sys_clk);
        {pcLoad, pcStep} <= 2'b00;
        {pcLoadValue, pcStepSize} <= ~{v, n};
    end
    endtask
endmodule // crs_dp_model

//--- test/crs_core_regs_tb.sv
// self-checking bench for the core register set
`timescale 1ns/100ps
`include "crs_regs.vh"
module crs_core_regs_tb;
    reg sys_clk;
    reg resetn;
    reg [3:0] avsAddress;
    reg avsRead;
    reg avsWrite;
    reg [31:0] avsWritedata;
    reg [3:0] avsByteenable;
    wire [31:0] avsReaddata;
    wire avsWaitrequest, aluValid, aluCarry, aluOverflow, pcLoad, pcStep, bankSelect;
    wire [15:0] aluResult;
    wire [15:0] activeStackPointer;
    wire [19:0] pcLoadValue;
    wire [19:0] programCounter;
    wire [2:0] pcStepSize;
    integer errCount;
    integer numChecks;
    integer cycles;
    integer i;
    reg [31:0] rdv;
    crs_dp_model u_dp (.sys_clk(sys_clk), .aluValid(aluValid), .aluResult(aluResult),
        .aluCarry(aluCarry), .aluOverflow(aluOverflow), .pcLoad(pcLoad),
        .pcLoadValue(pcLoadValue), .pcStep(pcStep), .pcStepSize(pcStepSize));
    crs_core_regs u_dut (.sys_clk(sys_clk), .resetn(resetn), .avs_address(avsAddress),
        .avs_read(avsRead), .avs_write(avsWrite), .avs_writedata(avsWritedata),
        .avs_byteenable(avsByteenable), .avs_readdata(avsReaddata),
        .avs_waitrequest(avsWaitrequest), .aluValid(aluValid), .aluResult(aluResult),
        .aluCarry(aluCarry), .aluOverflow(aluOverflow), .pcLoad(pcLoad),
        .pcLoadValue(pcLoadValue), .pcStep(pcStep), .pcStepSize(pcStepSize),
        .programCounter(programCounter), .activeStackPointer(activeStackPointer),
        .bankSelect(bankSelect));
    initial
    begin
        sys_clk = 1'b0;
        forever #10 sys_clk = ~sys_clk;
    end
    task summarize;
    begin
        $display("checks %0d errors %0d", numChecks, errCount);
        if (errCount == 0 && numChecks > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    end
    endtask
    always @(posedge sys_clk)
    begin
        cycles = cycles + 1;
        if (cycles == 5000)
        begin
            errCount = errCount + 1;
            summarize;
        end
    end
    task chk(input [31:0] got, input [31:0] exp);
    begin
        numChecks = numChecks + 1;
        if (got !== exp)
        begin
            errCount = errCount + 1;
            $display("[FAIL] %0t got %h expected %h", $time, got, exp);
        end
    end
    endtask
    // the leading edge keeps a new request from landing in the release time step
    task bus(input w, input [3:0] a, input [31:0] d, input [3:0] be);
    begin
        @(posedge sys_clk);
        {avsWrite, avsRead, avsAddress, avsWritedata, avsByteenable} <= {w, !w, a, d, be};
        @(posedge sys_clk);
        while (avsWaitrequest !== 1'b0)
            @(posedge sys_clk);
        rdv = avsReaddata;
        {avsWrite, avsRead} <= 2'b00;
    end
    endtask
    task rc(input [3:0] a, input [31:0] exp);
    begin
        bus(1'b0, a, 32'h0000_0000, 4'hF);
        chk(rdv, exp);
    end
    endtask
    initial
    begin
        {avsRead, avsWrite, avsAddress, avsWritedata, avsByteenable} = 42'h000_0000_0000;
        resetn = 1'b0;
        errCount = 0;
        numChecks = 0;
        cycles = 0;
        repeat (20) @(posedge sys_clk);
        resetn <= 1'b1;
        for (i = 0; i < 14; i = i + 1)
            rc(i[3:0], 32'h0000_0000);
        for (i = 2; i < 12; i = i + 1)
            bus(1'b1, i[3:0], 32'hFEDC_BA90 | i, 4'hF);
        for (i = 2; i < 12; i = i + 1)
            if (i != 4)
                rc(i[3:0], (32'hFEDC_BA90 | i) & ((i == 7 || i == 8) ? 32'h000F_FFFF : 32'h0000_FFFF));
        chk({16'h0000, activeStackPointer}, 32'h0000_BA9A);
        bus(1'b1, `CRS_OFF_DATA0, 32'h1234_5678, 4'hF);
        rc(`CRS_OFF_DATA0, 32'h1234_5678);
        rc(`CRS_OFF_DATA2, 32'h0000_1234);
        bus(1'b1, `CRS_OFF_ADDR0, 32'h9ABC_DEF0, 4'hF);
        rc(`CRS_OFF_ADDR1, 32'h0000_9ABC);
        bus(1'b1, `CRS_OFF_DATA1, 32'hBA93_1111, 4'hF);
        bus(1'b1, `CRS_OFF_DATA1, 32'h0000_00AB, 4'h1);
        rc(`CRS_OFF_DATA1, 32'hBA93_11AB);
        bus(1'b1, `CRS_OFF_DATA1, 32'h0000_CD00, 4'h2);
        rc(`CRS_OFF_DATA1, 32'hBA93_CDAB);
        bus(1'b1, `CRS_OFF_FLAG, 32'h0000_07FD, 4'hF);
        rc(`CRS_OFF_FLAG, 32'h0000_00BD);
        chk({31'h0, bankSelect}, 32'h0000_0001);
        chk({16'h0000, activeStackPointer}, 32'h0000_BA99);
        rc(`CRS_OFF_DATA0, 32'h0000_0000);
        bus(1'b1, `CRS_OFF_DATA0, 32'h5555_6666, 4'hF);
        bus(1'b1, `CRS_OFF_FLAG, 32'h0000_0000, 4'hF);
        rc(`CRS_OFF_DATA0, 32'h1234_5678);
        rc(`CRS_OFF_ASP, 32'h0000_BA9A);
        u_dp.alu(16'h0000, 1'b1, 1'b0);
        rc(`CRS_OFF_FLAG, 32'h0000_0005);
        u_dp.alu(16'h8001, 1'b0, 1'b1);
        rc(`CRS_OFF_FLAG, 32'h0000_0028);
        u_dp.pc(1'b1, 20'hA_BCDE, 3'h0);
        rc(`CRS_OFF_PC, 32'h000A_BCDE);
        u_dp.pc(1'b0, 20'h0_0000, 3'h7);
        rc(`CRS_OFF_PC, 32'h000A_BCE5);
        chk({12'h000, programCounter}, 32'h000A_BCE5);
        bus(1'b1, 4'hF, 32'hFFFF_FFFF, 4'hF);
        rc(4'hE, `CRS_UNMAPPED);
        rc(4'hF, `CRS_UNMAPPED);
        summarize;
    end
endmodule // crs_core_regs_tb
